// >>> rtl/fofd_pkg.sv
// Shared constants and types of the floating-point opcode and format decoder.
package fofd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Instruction word fields.
	localparam int OPC_HI     = 31;
	localparam int OPC_LO     = 26;
	localparam int FMT_HI     = 25;
	localparam int FMT_LO     = 21;
	localparam int SEL_ROW_HI = 25;
	localparam int SEL_ROW_LO = 24;
	localparam int SEL_COL_HI = 23;
	localparam int SEL_COL_LO = 21;
	localparam int TF_BIT     = 16;
	localparam int SFMT_HI    = 2;
	localparam int SFMT_LO    = 0;

	////////////////////////////////////////////////////////////////////////
	// Main opcodes of the three coprocessor groups.
	localparam logic [5:0] OPC_FLOAT  = 6'h11;
	localparam logic [5:0] OPC_SECOND_COPROCESSOR_OPCODE   = 6'h12;
	localparam logic [5:0] OPC_FLOATX = 6'h13;

	////////////////////////////////////////////////////////////////////////
	// Format field values.
	localparam logic [4:0] FMT_XFER_LAST = 5'h0f;
	localparam logic [4:0] FMT_SINGLE    = 5'h10;
	localparam logic [4:0] FMT_DOUBLE    = 5'h11;
	localparam logic [4:0] FMT_WORD      = 5'h14;
	localparam logic [4:0] FMT_LONG      = 5'h15;
	localparam logic [4:0] FMT_PAIRED    = 5'h16;
	localparam logic [4:0] XFER_BAD_LO   = 5'h0c;
	localparam logic [4:0] XFER_BAD_HI   = 5'h0e;

	////////////////////////////////////////////////////////////////////////
	// Function field codes.
	localparam logic [5:0] FN_COND_MOVE = 6'h11;
	localparam logic [2:0] FN_ROW_ARITH = 3'h0;
	localparam logic [2:0] FN_ROW_RSVD  = 3'h5;
	localparam logic [2:0] FN_ROW_ILD   = 3'h0;
	localparam logic [2:0] FN_ROW_IST   = 3'h1;
	localparam logic [1:0] FN_CMP_TOP   = 2'h3;
	localparam logic [2:0] FN_WL_CVT    = 3'h4;
	localparam logic [1:0] C2_ROW_MOVE  = 2'h0;
	localparam logic [1:0] C2_ROW_BR    = 2'h1;
	localparam logic [2:0] C2_COL_RSVD  = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Decoded data formats; the codes equal the short format codes.
	typedef enum logic [2:0] {
		FMT_S    = 3'h0,
		FMT_D    = 3'h1,
		FMT_W    = 3'h4,
		FMT_L    = 3'h5,
		FMT_PS   = 3'h6,
		FMT_NONE = 3'h7
	} fofd_fmt_t;

	typedef enum logic [3:0] {
		CLS_NONE   = 4'h0,
		CLS_XFER   = 4'h1,
		CLS_ARITH  = 4'h2,
		CLS_CMOVE  = 4'h3,
		CLS_CMP    = 4'h4,
		CLS_OTHER  = 4'h5,
		CLS_ILOAD  = 4'h6,
		CLS_ISTORE = 4'h7,
		CLS_FMA    = 4'h8,
		CLS_C2MOVE = 4'h9,
		CLS_C2BR   = 4'ha,
		CLS_C2OP   = 4'hb
	} fofd_cls_t;

	typedef enum logic [2:0] {
		AR_ADD  = 3'h0,
		AR_SUB  = 3'h1,
		AR_MUL  = 3'h2,
		AR_DIV  = 3'h3,
		AR_SQRT = 3'h4,
		AR_ABS  = 3'h5,
		AR_MOV  = 3'h6,
		AR_NEG  = 3'h7
	} fofd_arith_t;

	typedef enum logic [1:0] {
		FMA_MADD  = 2'h0,
		FMA_MSUB  = 2'h1,
		FMA_NMADD = 2'h2,
		FMA_NMSUB = 2'h3
	} fofd_fma_t;

endpackage : fofd_pkg

// >>> rtl/fofd_fmt_if.sv
// Carrier between the main decoder and its format field decoder.
`timescale 1ns/1ps
`default_nettype none
interface fofd_fmt_if;
	logic [4:0]          long_code;
	logic [2:0]          short_code;
	logic                fp64_en;
	logic                is_xfer;
	logic                long_ok;
	fofd_pkg::fofd_fmt_t long_fmt;
	logic                short_ok;
	fofd_pkg::fofd_fmt_t short_fmt;

	modport dec (
		input  long_code,
		input  short_code,
		input  fp64_en,
		output is_xfer,
		output long_ok,
		output long_fmt,
		output short_ok,
		output short_fmt
	);
	modport use_side (
		output long_code,
		output short_code,
		output fp64_en,
		input  is_xfer,
		input  long_ok,
		input  long_fmt,
		input  short_ok,
		input  short_fmt
	);
endinterface : fofd_fmt_if
`default_nettype wire

// >>> rtl/fofd_fmt_dec.sv
// Combinational decode of the five-bit and three-bit format fields.
`timescale 1ns/1ps
`default_nettype none
module fofd_fmt_dec (
	fofd_fmt_if.dec f
);

	////////////////////////////////////////////////////////////////////////
	// Values up to the last transfer code carry no format at all.
	always_comb begin
		f.is_xfer = (f.long_code <= fofd_pkg::FMT_XFER_LAST);
	end

	// Codes 18, 19, 23 and 24 to 31 fall to the default as reserved.
	always_comb begin
		f.long_fmt = fofd_pkg::FMT_NONE;
		f.long_ok  = 1'b0;
		case (f.long_code)
			fofd_pkg::FMT_SINGLE: begin
				f.long_fmt = fofd_pkg::FMT_S;
				f.long_ok  = 1'b1;
			end
			fofd_pkg::FMT_DOUBLE: begin
				f.long_fmt = fofd_pkg::FMT_D;
				f.long_ok  = 1'b1;
			end
			fofd_pkg::FMT_WORD: begin
				f.long_fmt = fofd_pkg::FMT_W;
				f.long_ok  = 1'b1;
			end
			fofd_pkg::FMT_LONG: begin
				f.long_fmt = fofd_pkg::FMT_L;
				f.long_ok  = f.fp64_en;
			end
			fofd_pkg::FMT_PAIRED: begin
				f.long_fmt = fofd_pkg::FMT_PS;
				f.long_ok  = f.fp64_en;
			end
			default: begin
				f.long_fmt = fofd_pkg::FMT_NONE;
				f.long_ok  = 1'b0;
			end
		endcase
	end

	// The short codes equal the enum codes, so only legality is decided.
	always_comb begin
		f.short_fmt = fofd_pkg::FMT_NONE;
		f.short_ok  = 1'b0;
		case (f.short_code)
			3'h0, 3'h1, 3'h4: begin
				f.short_fmt = fofd_pkg::fofd_fmt_t'(f.short_code);
				f.short_ok  = 1'b1;
			end
			3'h5, 3'h6: begin
				f.short_fmt = fofd_pkg::fofd_fmt_t'(f.short_code);
				f.short_ok  = f.fp64_en;
			end
			default: begin
				f.short_fmt = fofd_pkg::FMT_NONE;
				f.short_ok  = 1'b0;
			end
		endcase
	end

endmodule : fofd_fmt_dec
`default_nettype wire

// >>> rtl/fofd_top.sv
// Registered decoder for the floating-point and second coprocessor opcodes.
//
// Overview of operation
// - Format of a float instruction comes from bits 25..21.
// - Format of an extended float instruction comes from bits 2..0.
// - Format values 0 to 15 mean transfer or control, not a format.
// - Formats 16,17,20,21,22 and short codes 0,1,4,5,6 are S,D,W,L,PS.
// - Format values 18,19,23 and short codes 2,3,7 are reserved.
// - Format values 24 to 31 are reserved.
// - Long and paired-single formats are legal only with 64-bit float on.
// - Conditional move: bit 16 low moves if false, high moves if true.
// - Function codes 0 to 7 are add,sub,mul,div,sqrt,abs,mov,neg.
// - Function upper bits 110 or 111 are compares; low bits the condition.
// - Extended rows 0,1 are indexed load,store; rows 4 to 7 fused ops.
// - Second coprocessor: row 0 moves, row 1 branch, rows 2,3 own ops.
`timescale 1ns/1ps
`default_nettype none
module fofd_top (
	// Clock and reset.
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// Instruction from the decode stage.
	input  wire logic                 in_valid,
	input  wire logic [31:0]          in_instr,
	input  wire logic                 fp64_en,
	// Decode result, one cycle later.
	output var  logic                 dec_valid,
	output var  logic                 dec_invalid,
	output var  fofd_pkg::fofd_cls_t   dec_class,
	output var  fofd_pkg::fofd_fmt_t   dec_fmt,
	output var  fofd_pkg::fofd_arith_t dec_arith,
	output var  fofd_pkg::fofd_fma_t   dec_fma,
	output var  logic [2:0]           dec_cond,
	output var  logic                 dec_cond_sig,
	output var  logic                 true_false_select
);

	////////////////////////////////////////////////////////////////////////
	// Field slices and the format decoder.
	logic [5:0] opc;
	logic [5:0] funct;
	logic [4:0] fcode;
	logic [1:0] sel_row;
	logic [2:0] sel_col;
	logic       wl_fmt;

	fofd_fmt_if fi ();

	assign opc     = in_instr[fofd_pkg::OPC_HI:fofd_pkg::OPC_LO];
	assign funct   = in_instr[5:0];
	assign fcode   = in_instr[fofd_pkg::FMT_HI:fofd_pkg::FMT_LO];
	assign sel_row = in_instr[fofd_pkg::SEL_ROW_HI:fofd_pkg::SEL_ROW_LO];
	assign sel_col = in_instr[fofd_pkg::SEL_COL_HI:fofd_pkg::SEL_COL_LO];

	assign fi.long_code  = fcode;
	assign fi.short_code = in_instr[fofd_pkg::SFMT_HI:fofd_pkg::SFMT_LO];
	assign fi.fp64_en    = fp64_en;

	fofd_fmt_dec u_fmt (
		.f (fi)
	);

	assign wl_fmt = (fi.long_fmt == fofd_pkg::FMT_W) ||
			(fi.long_fmt == fofd_pkg::FMT_L);

	////////////////////////////////////////////////////////////////////////
	// Next-state decode.
	fofd_pkg::fofd_cls_t   cls_d;
	fofd_pkg::fofd_fmt_t   fmt_d;
	fofd_pkg::fofd_arith_t arith_d;
	fofd_pkg::fofd_fma_t   fma_d;
	logic [2:0]            cond_d;
	logic                  sig_d;
	logic                  tf_d;
	logic                  inval_d;

	always_comb begin
		cls_d   = fofd_pkg::CLS_NONE;
		fmt_d   = fofd_pkg::FMT_NONE;
		arith_d = fofd_pkg::AR_ADD;
		fma_d   = fofd_pkg::FMA_MADD;
		cond_d  = 3'h0;
		sig_d   = 1'b0;
		tf_d    = 1'b0;
		inval_d = 1'b0;
		case (opc)
			fofd_pkg::OPC_FLOAT: begin
				if (fi.is_xfer) begin
					cls_d   = fofd_pkg::CLS_XFER;
					inval_d = (fcode >= fofd_pkg::XFER_BAD_LO) &&
						(fcode <= fofd_pkg::XFER_BAD_HI);
				end else if (!fi.long_ok) begin
					inval_d = 1'b1;
				end else begin
					fmt_d = fi.long_fmt;
					if (funct[5:4] == fofd_pkg::FN_CMP_TOP) begin
						cls_d   = fofd_pkg::CLS_CMP;
						cond_d  = funct[2:0];
						sig_d   = funct[3];
						inval_d = wl_fmt;
					end else if (funct == fofd_pkg::FN_COND_MOVE) begin
						cls_d   = fofd_pkg::CLS_CMOVE;
						tf_d    = in_instr[fofd_pkg::TF_BIT];
						inval_d = wl_fmt;
					end else if (funct[5:3] == fofd_pkg::FN_ROW_ARITH) begin
						cls_d   = fofd_pkg::CLS_ARITH;
						arith_d = fofd_pkg::fofd_arith_t'(funct[2:0]);
						// Paired single has no divide or square root.
						inval_d = wl_fmt ||
							((fi.long_fmt == fofd_pkg::FMT_PS) &&
							((funct[2:0] == 3'h3) ||
							(funct[2:0] == 3'h4)));
					end else if (funct[5:3] == fofd_pkg::FN_ROW_RSVD) begin
						inval_d = 1'b1;
					end else begin
						cls_d   = fofd_pkg::CLS_OTHER;
						inval_d = wl_fmt &&
							(funct[5:3] != fofd_pkg::FN_WL_CVT);
					end
				end
			end
			fofd_pkg::OPC_FLOATX: begin
				unique case (funct[5:3])
					fofd_pkg::FN_ROW_ILD: begin
						cls_d = fofd_pkg::CLS_ILOAD;
					end
					fofd_pkg::FN_ROW_IST: begin
						cls_d = fofd_pkg::CLS_ISTORE;
					end
					3'h4, 3'h5, 3'h6, 3'h7: begin
						cls_d   = fofd_pkg::CLS_FMA;
						fma_d   = fofd_pkg::fofd_fma_t'(funct[4:3]);
						fmt_d   = fi.short_fmt;
						inval_d = !fi.short_ok;
					end
					3'h2, 3'h3: begin
						inval_d = 1'b1;
					end
				endcase
			end
			fofd_pkg::OPC_SECOND_COPROCESSOR_OPCODE: begin
				unique case (sel_row)
					fofd_pkg::C2_ROW_MOVE: begin
						cls_d   = fofd_pkg::CLS_C2MOVE;
						inval_d = (sel_col == fofd_pkg::C2_COL_RSVD);
					end
					fofd_pkg::C2_ROW_BR: begin
						cls_d   = fofd_pkg::CLS_C2BR;
						inval_d = (sel_col != 3'h0);
					end
					2'h2, 2'h3: begin
						cls_d = fofd_pkg::CLS_C2OP;
					end
				endcase
			end
			default: begin
				cls_d = fofd_pkg::CLS_NONE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Result registers; a word not marked valid clears valid, class, format and invalid, while the other result fields hold.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_valid <= 1'b0;
		end else begin
			dec_valid <= in_valid;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_invalid <= 1'b0;
			dec_class   <= fofd_pkg::CLS_NONE;
			dec_fmt     <= fofd_pkg::FMT_NONE;
		end else begin
			dec_invalid <= in_valid && inval_d;
			dec_class   <= in_valid ? cls_d : fofd_pkg::CLS_NONE;
			dec_fmt     <= in_valid ? fmt_d : fofd_pkg::FMT_NONE;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_arith         <= fofd_pkg::AR_ADD;
			dec_fma           <= fofd_pkg::FMA_MADD;
			dec_cond          <= 3'h0;
			dec_cond_sig      <= 1'b0;
			true_false_select <= 1'b0;
		end else if (in_valid) begin
			dec_arith         <= arith_d;
			dec_fma           <= fma_d;
			dec_cond          <= cond_d;
			dec_cond_sig      <= sig_d;
			true_false_select <= tf_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the registered result against the word that caused it.
	long_fmt_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT &&
		fcode == fofd_pkg::FMT_DOUBLE && funct == 6'h00
		|=> dec_fmt == fofd_pkg::FMT_D && !dec_invalid)
		else $error("double format not decoded");

	short_fmt_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOATX && funct[5] &&
		funct[2:0] == 3'h4
		|=> dec_fmt == fofd_pkg::FMT_W && dec_class == fofd_pkg::CLS_FMA)
		else $error("short format not decoded");

	xfer_class_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT && fcode < 5'h10
		|=> dec_class == fofd_pkg::CLS_XFER &&
		dec_fmt == fofd_pkg::FMT_NONE)
		else $error("transfer range given a format");

	rsvd_fmt_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT &&
		(fcode == 5'h12 || fcode == 5'h13 || fcode >= 5'h17)
		|=> dec_invalid)
		else $error("reserved format accepted");

	fp64_gate_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && !fp64_en && opc == fofd_pkg::OPC_FLOAT &&
		(fcode == 5'h15 || fcode == 5'h16)
		|=> dec_invalid && dec_class == fofd_pkg::CLS_NONE)
		else $error("64-bit format accepted while disabled");

	tf_select_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT && funct == 6'h11 &&
		fcode == 5'h10
		|=> dec_class == fofd_pkg::CLS_CMOVE &&
		true_false_select == $past(in_instr[16]))
		else $error("true or false select wrong");

	arith_map_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT &&
		fcode == 5'h11 && funct[5:3] == 3'h0
		|=> dec_class == fofd_pkg::CLS_ARITH &&
		dec_arith == $past(funct[2:0]))
		else $error("arithmetic map wrong");

	cmp_cond_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT &&
		fcode == 5'h10 && funct[5:4] == 2'h3
		|=> dec_class == fofd_pkg::CLS_CMP &&
		dec_cond == $past(funct[2:0]))
		else $error("compare condition wrong");

	fma_map_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOATX && funct[5] &&
		funct[2:0] == 3'h0
		|=> dec_class == fofd_pkg::CLS_FMA && !dec_invalid &&
		dec_fma == $past(funct[4:3]))
		else $error("fused operation map wrong");

	second_coprocessor_opcode_row_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_SECOND_COPROCESSOR_OPCODE && sel_row[1]
		|=> dec_class == fofd_pkg::CLS_C2OP && !dec_invalid)
		else $error("second coprocessor row wrong");

	rsvd_row_a : assert property (
		@(posedge core_clk) disable iff (sys_rst)
		in_valid && opc == fofd_pkg::OPC_FLOAT && !fi.is_xfer &&
		funct[5:3] == 3'h5
		|=> dec_invalid)
		else $error("reserved function row accepted");

endmodule : fofd_top
`default_nettype wire

// >>> verif/fofd_feeder.sv
// Decode-stage model that hands instruction words to the decoder.
`timescale 1ns/1ps
`default_nettype none
module fofd_feeder (
	// Word toward the decoder.
	output var logic        in_valid,
	output var logic [31:0] in_instr,
	output var logic        fp64_en
);
	initial begin
		in_valid = 1'b0;
		in_instr = 32'h0000_0000;
		fp64_en  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Called just after a rising edge; the word stands until the next call.
	task automatic put(input logic [31:0] word, input logic f64);
		in_valid = 1'b1;
		in_instr = word;
		fp64_en  = f64;
	endtask : put

	// An idle stage leaves no stale word behind, so the bus shows its inverse.
	task automatic idle();
		in_valid = 1'b0;
		in_instr = ~in_instr;
		fp64_en  = ~fp64_en;
	endtask : idle
endmodule : fofd_feeder
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the opcode and format decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                  core_clk;
	logic                  sys_rst;
	logic                  in_valid;
	logic [31:0]           in_instr;
	logic                  fp64_en;
	logic                  dec_valid;
	logic                  dec_invalid;
	fofd_pkg::fofd_cls_t   dec_class;
	fofd_pkg::fofd_fmt_t   dec_fmt;
	fofd_pkg::fofd_arith_t dec_arith;
	fofd_pkg::fofd_fma_t   dec_fma;
	logic [2:0]            dec_cond;
	logic                  dec_cond_sig;
	logic                  true_false_select;
	int                    n_fail = 0;
	int                    total_checks = 0;

	fofd_feeder feeder (
		.in_valid (in_valid),
		.in_instr (in_instr),
		.fp64_en  (fp64_en)
	);

	fofd_top uut (
		.core_clk          (core_clk),
		.sys_rst           (sys_rst),
		.in_valid          (in_valid),
		.in_instr          (in_instr),
		.fp64_en           (fp64_en),
		.dec_valid         (dec_valid),
		.dec_invalid       (dec_invalid),
		.dec_class         (dec_class),
		.dec_fmt           (dec_fmt),
		.dec_arith         (dec_arith),
		.dec_fma           (dec_fma),
		.dec_cond          (dec_cond),
		.dec_cond_sig      (dec_cond_sig),
		.true_false_select (true_false_select)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic note(input logic ok, input logic [7:0] got, exp);
		total_checks++;
		if (!ok) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : note

	task automatic chk_bit(input logic got, input logic exp);
		note(got === exp, {7'h00, got}, {7'h00, exp});
	endtask : chk_bit

	task automatic chk_num(input logic [3:0] got, input logic [3:0] exp);
		note(got === exp, {4'h0, got}, {4'h0, exp});
	endtask : chk_num

	task automatic chk_cls(input fofd_pkg::fofd_cls_t got, exp);
		note(got === exp, {4'h0, got}, {4'h0, exp});
	endtask : chk_cls

	task automatic chk_fmt(input fofd_pkg::fofd_fmt_t got, exp);
		note(got === exp, {5'h00, got}, {5'h00, exp});
	endtask : chk_fmt

	function automatic logic [31:0] mk(input logic [5:0] opc,
		input logic [4:0] fld, input logic b16, input logic [5:0] fn);
		return {opc, fld, 4'h0, b16, 10'h000, fn};
	endfunction : mk

	// The word is taken at the next edge and answered by that same edge.
	task automatic issue(input logic [31:0] w, input logic f64);
		feeder.put(w, f64);
		@(posedge core_clk);
		#1;
	endtask : issue

	task automatic res(input logic inv, input fofd_pkg::fofd_cls_t cls);
		chk_bit(dec_valid, 1'b1);
		chk_bit(dec_invalid, inv);
		if (!inv)
			chk_cls(dec_class, cls);
	endtask : res

	task automatic gap();
		feeder.idle();
		@(posedge core_clk);
		#1;
		chk_bit(dec_valid, 1'b0);
		chk_cls(dec_class, fofd_pkg::CLS_NONE);
		chk_fmt(dec_fmt, fofd_pkg::FMT_NONE);
	endtask : gap

	////////////////////////////////////////////////////////////////////////
	task automatic t_formats();
		logic ok;
		for (int i = 0; i < 32; i++) begin
			ok = (i < 12) || (i inside {15, 16, 17, 20, 21, 22});
			issue(mk(fofd_pkg::OPC_FLOAT, 5'(i), 1'b0, 6'h20), 1'b1);
			if (i < 16) begin
				res(!ok, fofd_pkg::CLS_XFER);
			end else if (ok) begin
				res(1'b0, fofd_pkg::CLS_OTHER);
				chk_fmt(dec_fmt, fofd_pkg::fofd_fmt_t'(3'(i - 16)));
			end else begin
				res(1'b1, fofd_pkg::CLS_NONE);
			end
		end
		issue(mk(6'h00, 5'h11, 1'b0, 6'h00), 1'b1);
		res(1'b0, fofd_pkg::CLS_NONE);
		gap();
	endtask : t_formats

	task automatic t_fp64_off();
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_LONG, 1'b0, 6'h20), 1'b0);
		res(1'b1, fofd_pkg::CLS_NONE);
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_PAIRED, 1'b0, 6'h20), 1'b0);
		res(1'b1, fofd_pkg::CLS_NONE);
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_WORD, 1'b0, 6'h20), 1'b0);
		res(1'b0, fofd_pkg::CLS_OTHER);
		issue(mk(fofd_pkg::OPC_FLOATX, 5'h00, 1'b0, 6'h26), 1'b0);
		chk_bit(dec_invalid, 1'b1);
		gap();
	endtask : t_fp64_off

	task automatic t_arith();
		for (int i = 0; i < 8; i++) begin
			issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_DOUBLE, 1'b0, 6'(i)), 1'b1);
			res(1'b0, fofd_pkg::CLS_ARITH);
			chk_fmt(dec_fmt, fofd_pkg::FMT_D);
			chk_num({1'b0, dec_arith}, 4'(i));
		end
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_WORD, 1'b0, 6'h00), 1'b1);
		chk_bit(dec_invalid, 1'b1);
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_PAIRED, 1'b0, 6'h03), 1'b1);
		chk_bit(dec_invalid, 1'b1);
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_DOUBLE, 1'b0, 6'h28),
			1'b1);
		chk_bit(dec_invalid, 1'b1);
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_WORD, 1'b0, 6'h08),
			1'b1);
		chk_bit(dec_invalid, 1'b1);
		gap();
	endtask : t_arith

	task automatic t_compare();
		for (int i = 0; i < 16; i++) begin
			issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_SINGLE, 1'b0,
				6'h30 + 6'(i)), 1'b1);
			res(1'b0, fofd_pkg::CLS_CMP);
			chk_num({1'b0, dec_cond}, {1'b0, 3'(i)});
			chk_bit(dec_cond_sig, i[3]);
		end
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_WORD, 1'b0, 6'h32), 1'b1);
		chk_bit(dec_invalid, 1'b1);
		gap();
	endtask : t_compare

	task automatic t_cmove();
		logic [4:0] fl [3] = '{5'h10, 5'h11, 5'h16};
		for (int k = 0; k < 6; k++) begin
			issue(mk(fofd_pkg::OPC_FLOAT, fl[k / 2], k[0],
				fofd_pkg::FN_COND_MOVE), 1'b1);
			res(1'b0, fofd_pkg::CLS_CMOVE);
			chk_bit(true_false_select, k[0]);
		end
		// Word format has no conditional move; the select bit is kept high.
		issue(mk(fofd_pkg::OPC_FLOAT, fofd_pkg::FMT_WORD, 1'b1,
			fofd_pkg::FN_COND_MOVE), 1'b1);
		chk_bit(dec_invalid, 1'b1);
		gap();
		// The select holds through idle cycles.
		chk_bit(true_false_select, 1'b1);
	endtask : t_cmove

	task automatic t_extended();
		logic bad;
		for (int r = 0; r < 8; r++) begin
			issue(mk(fofd_pkg::OPC_FLOATX, 5'h00, 1'b0, {3'(r), 3'h1}), 1'b1);
			if (r < 2) begin
				res(1'b0, r == 0 ? fofd_pkg::CLS_ILOAD
					: fofd_pkg::CLS_ISTORE);
			end else if (r < 4) begin
				res(1'b1, fofd_pkg::CLS_NONE);
			end else begin
				res(1'b0, fofd_pkg::CLS_FMA);
				chk_num({2'b00, dec_fma}, 4'(r - 4));
			end
		end
		for (int c = 0; c < 8; c++) begin
			bad = c inside {2, 3, 7};
			issue(mk(fofd_pkg::OPC_FLOATX, 5'h00, 1'b0, {3'h4, 3'(c)}), 1'b1);
			chk_bit(dec_invalid, bad);
			if (!bad)
				chk_fmt(dec_fmt, fofd_pkg::fofd_fmt_t'(3'(c)));
		end
		gap();
	endtask : t_extended

	task automatic t_second();
		logic [4:0] fld [7] = '{5'h00, 5'h05, 5'h04, 5'h08, 5'h09, 5'h11, 5'h1f};
		logic [6:0] bad = 7'b001_0100;
		fofd_pkg::fofd_cls_t ec;
		for (int k = 0; k < 7; k++) begin
			ec = fld[k][4] ? fofd_pkg::CLS_C2OP
				: fld[k][3] ? fofd_pkg::CLS_C2BR : fofd_pkg::CLS_C2MOVE;
			issue(mk(fofd_pkg::OPC_SECOND_COPROCESSOR_OPCODE, fld[k], 1'b0, 6'h00), 1'b1);
			res(bad[k], ec);
		end
		gap();
	endtask : t_second

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		sys_rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk_bit(dec_valid, 1'b0);
		chk_cls(dec_class, fofd_pkg::CLS_NONE);
		chk_fmt(dec_fmt, fofd_pkg::FMT_NONE);
		sys_rst = 1'b0;
		t_formats();
		t_fp64_off();
		t_arith();
		t_compare();
		t_cmove();
		t_extended();
		t_second();
		final_report();
	end

	// About 105 cycles are needed; the limit allows many times that.
	initial begin
		#20000;
		n_fail++;
		final_report();
	end
endmodule : tb
`default_nettype wire
